// >>> bsem_top.sv
// Event, mask and live status block of one bisync serial channel
//
// Function
// - Sixteen-bit event register; each recognised event sets its own bit.
// - Writing ones clears those event bits; zeros leave bits alone; reads anytime.
// - Interrupt stays high while any unmasked event bit remains set.
// - Reset clears the event register.
// - Event bit positions 12,11,10,7,4,3,2,1,0; others reserved.
// - Receive and transmit clock glitches set their own events.
// - Carrier sense change from the phase loop sets its event.
// - Graceful halt done sets after the running message ends, or at once.
// - Lost clear-to-send or underrun during sending sets send fault.
// - Each character written to the receive buffer sets char received.
// - No buffer: discard character, set busy, wait for hunt command.
// - Buffer sent sets when last bit or check sequence starts.
// - Closing a receive buffer sets buffer received.
// - Sixteen-bit mask register, same layout, one enables, reset clears.
// - Eight-bit read-only live line condition register.
// - Carrier sense bit shows the phase loop carrier sense.
// - Transmit length is never altered; software keeps it above zero.
// - Transparent receive strips escape and sees controls only after it.
// - Sync and stripped escape characters are left out of the check sum.
// - Check restart command clears the check sum; the next character is accumulated.
// - Enquiry ends the block with no check sequence expected.
`timescale 1ns/1ps
module bsem_top (
    input  wire logic               mclk_i,
    input  wire logic               srst_i,
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [11:0]        paddr_i,
    input  wire logic [31:0]        pwdata_i,
    input  wire logic [3:0]         pstrb_i,
    output logic      [31:0]        prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    input  wire bsem_pkg::bsem_line_s line_i,
    input  wire logic               carrier_sense_i,
    input  wire bsem_pkg::bsem_char_s rx_char_i,
    output bsem_pkg::bsem_char_s    rx_store_o,
    output logic                    block_end_o,
    output logic                    check_expected_o,
    output logic [7:0]              check_sum_o,
    output logic                    rx_hunting_o,
    output logic [15:0]             tx_length_o,
    output logic                    irq_o
);
    // Bus decode
    wire        acc      = psel_i & penable_i;
    wire        wr_acc   = acc & pwrite_i;
    wire        hit_evt  = paddr_i == bsem_pkg::EVT_OFF;
    wire        hit_msk  = paddr_i == bsem_pkg::MSK_OFF;
    wire        hit_sts  = paddr_i == bsem_pkg::STS_OFF;
    wire        hit_ctl  = paddr_i == bsem_pkg::CTL_OFF;
    wire        hit_chk  = paddr_i == bsem_pkg::CHK_OFF;
    wire        hit_dat  = paddr_i == bsem_pkg::DAT_OFF;
    wire        hit_txl  = paddr_i == bsem_pkg::TXL_OFF;
    wire        mapped   = hit_evt | hit_msk | hit_sts | hit_ctl | hit_chk | hit_dat | hit_txl;
    wire [15:0] wmask16  = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
    wire [15:0] wdata16  = pwdata_i[15:0] & wmask16;

    assign pready_o  = 1'b1;
    assign pslverr_o = acc & ~mapped;

    logic [15:0] evt_q, evt_d, msk_q, msk_d, tx_len_q;
    logic [7:0]  esc_q, syn_q, enq_q, etx_q;
    logic        trn_q, hunt_q, cs_q, gra_pend_q, esc_seen_q, in_block_q;
    logic        crst_q;
    logic [7:0]  sum_q;
    logic [31:0] prdata_q;
    bsem_pkg::bsem_char_s store_q;
    logic        bend_q, chkexp_q;

    // Control register commands are one-shot on write
    wire cmd_wr   = wr_acc & hit_ctl & pstrb_i[0];
    wire cmd_hunt = cmd_wr & pwdata_i[bsem_pkg::CTL_HUNT];
    wire cmd_gra  = cmd_wr & pwdata_i[bsem_pkg::CTL_GRA];
    wire cmd_crst = cmd_wr & pwdata_i[bsem_pkg::CTL_CRST];

    // Receive character classification
    wire rc       = rx_char_i.valid & ~hunt_q;
    wire is_syn   = rx_char_i.data == syn_q;
    wire is_esc   = rx_char_i.data == esc_q;
    wire is_ctl   = (rx_char_i.data == enq_q) | (rx_char_i.data == etx_q);
    wire strip    = trn_q & is_esc & ~esc_seen_q;
    wire ctl_ok   = is_ctl & (~trn_q | esc_seen_q);
    wire to_store = rc & ~is_syn & ~strip;
    wire stored   = to_store & line_i.rx_buf_avail;
    wire dropped  = to_store & ~line_i.rx_buf_avail;
    wire is_enq   = ctl_ok & (rx_char_i.data == enq_q);
    wire in_sum   = stored & ~crst_q;

    // Graceful halt completes now if idle, else at message end
    wire gra_done = (cmd_gra & ~line_i.tx_msg_active) |
                    (gra_pend_q & ~line_i.tx_msg_active);

    logic [15:0] ev_set;
    always_comb begin
        ev_set = '0;
        ev_set[bsem_pkg::EV_GLR] = line_i.rx_clk_glitch;
        ev_set[bsem_pkg::EV_GLT] = line_i.tx_clk_glitch;
        ev_set[bsem_pkg::EV_DCC] = carrier_sense_i ^ cs_q;
        ev_set[bsem_pkg::EV_GRA] = gra_done;
        ev_set[bsem_pkg::EV_TXE] = line_i.tx_msg_active &
                                   (line_i.tx_cts_lost | line_i.tx_underrun);
        ev_set[bsem_pkg::EV_RCH] = stored;
        ev_set[bsem_pkg::EV_BSY] = dropped;
        ev_set[bsem_pkg::EV_TX]  = line_i.tx_last_bit;
        ev_set[bsem_pkg::EV_RX]  = line_i.rx_buf_closed;
    end

    // Set wins over a same-cycle clear
    wire [15:0] ev_clr = (wr_acc & hit_evt) ? wdata16 : 16'h0000;
    assign evt_d = ((evt_q & ~ev_clr) | ev_set) & bsem_pkg::EV_VALID;
    assign msk_d = (wr_acc & hit_msk) ?
                   (((msk_q & ~wmask16) | wdata16) & bsem_pkg::EV_VALID) : msk_q;

    assign irq_o = |(evt_q & msk_q);

    // Register read mux
    wire [31:0] rd_mux =
        hit_evt ? {16'h0000, evt_q} :
        hit_msk ? {16'h0000, msk_q} :
        hit_sts ? {24'h000000, 6'h00, cs_q, 1'b0} :
        hit_ctl ? {28'h0000000, 2'b00, hunt_q, trn_q} :
        hit_chk ? {etx_q, enq_q, syn_q, esc_q} :
        hit_dat ? {24'h000000, sum_q} :
        hit_txl ? {16'h0000, tx_len_q} : 32'h00000000;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            evt_q <= bsem_pkg::EV_RESET;
            msk_q <= bsem_pkg::MSK_RESET;
        end else begin
            evt_q <= evt_d;
            msk_q <= msk_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cs_q       <= 1'b0;
            gra_pend_q <= 1'b0;
            trn_q      <= 1'b0;
            hunt_q     <= 1'b1;
        end else begin
            cs_q       <= carrier_sense_i;
            gra_pend_q <= (gra_pend_q | cmd_gra) & line_i.tx_msg_active;
            if (cmd_wr) begin
                trn_q <= pwdata_i[bsem_pkg::CTL_TRN];
            end
            if (cmd_hunt) begin
                hunt_q <= 1'b0;
            end else if (dropped | (ctl_ok & rc)) begin
                hunt_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            esc_q <= bsem_pkg::ESC_RESET;
            syn_q <= bsem_pkg::SYN_RESET;
            enq_q <= bsem_pkg::ENQ_RESET;
            etx_q <= bsem_pkg::ETX_RESET;
        end else if (wr_acc & hit_chk) begin
            if (pstrb_i[0]) esc_q <= pwdata_i[7:0];
            if (pstrb_i[1]) syn_q <= pwdata_i[15:8];
            if (pstrb_i[2]) enq_q <= pwdata_i[23:16];
            if (pstrb_i[3]) etx_q <= pwdata_i[31:24];
        end
    end

    // Transmit length is stored only by software
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            tx_len_q <= 16'h0001;
        end else if (wr_acc & hit_txl) begin
            tx_len_q <= (tx_len_q & ~wmask16) | wdata16;
        end
    end

    // Receive path, escape tracking and check accumulation
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            esc_seen_q <= 1'b0;
            sum_q      <= 8'h00;
            crst_q     <= 1'b0;
            store_q    <= '0;
            bend_q     <= 1'b0;
            chkexp_q   <= 1'b0;
            in_block_q <= 1'b0;
        end else begin
            if (rc) begin
                esc_seen_q <= strip;
            end
            crst_q <= 1'b0;
            if (cmd_crst) begin
                sum_q <= 8'h00;
            end else if (in_sum) begin
                sum_q <= sum_q ^ rx_char_i.data;
            end
            store_q.valid <= stored;
            if (stored) begin
                store_q.data <= rx_char_i.data;
            end
            bend_q   <= rc & ctl_ok;
            chkexp_q <= rc & ctl_ok & ~is_enq;
            if (rc & ~is_syn) begin
                in_block_q <= ~ctl_ok;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            prdata_q <= 32'h00000000;
        end else if (psel_i & ~penable_i & ~pwrite_i) begin
            prdata_q <= rd_mux;
        end
    end
    assign prdata_o = prdata_q;

    assign rx_store_o       = store_q;
    assign block_end_o      = bend_q;
    assign check_expected_o = chkexp_q;
    assign check_sum_o      = sum_q;
    assign rx_hunting_o     = hunt_q;
    assign tx_length_o      = tx_len_q;

    // Assertions
    a_irq_masked_events: assert property (@(posedge mclk_i) disable iff (srst_i)
        irq_o == |(evt_q & msk_q)) else $error("irq not tied to masked events");
    a_evt_w1c_clear: assert property (@(posedge mclk_i) disable iff (srst_i)
        (wr_acc & hit_evt & (pstrb_i == 4'hf) & (ev_set == 16'h0000)) |=>
        evt_q == ($past(evt_q) & ~$past(pwdata_i[15:0]))) else $error("w1c failed");
    a_evt_set_wins: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ev_set[bsem_pkg::EV_RX]) |=> evt_q[bsem_pkg::EV_RX]) else $error("rx event lost");
    a_evt_reserved_zero: assert property (@(posedge mclk_i)
        ((evt_q | msk_q) & ~bsem_pkg::EV_VALID) == 16'h0000) else $error("reserved bit set");
    a_evt_reset_clear: assert property (@(posedge mclk_i)
        srst_i |=> (evt_q == 16'h0000) && (msk_q == 16'h0000)) else $error("reset not cleared");
    a_busy_hunts: assert property (@(posedge mclk_i) disable iff (srst_i)
        dropped |=> evt_q[bsem_pkg::EV_BSY] && rx_hunting_o) else $error("busy not taken");
    a_enq_no_check: assert property (@(posedge mclk_i) disable iff (srst_i)
        (rc & is_enq) |=> block_end_o && !check_expected_o) else $error("enq expects check");
    a_status_cs: assert property (@(posedge mclk_i) disable iff (srst_i)
        ##1 cs_q == $past(carrier_sense_i)) else $error("cs status stale");
    a_strip_escape: assert property (@(posedge mclk_i) disable iff (srst_i)
        (rc & strip) |=> !rx_store_o.valid) else $error("escape stored");
    a_gra_idle_now: assert property (@(posedge mclk_i) disable iff (srst_i)
        (cmd_gra & ~line_i.tx_msg_active) |=> evt_q[bsem_pkg::EV_GRA]) else $error("gra late");
    a_rx_glitch_sets: assert property (@(posedge mclk_i) disable iff (srst_i)
        line_i.rx_clk_glitch
        |=> evt_q[bsem_pkg::EV_GLR]) else $error("rx glitch event lost");
    a_tx_glitch_sets: assert property (@(posedge mclk_i) disable iff (srst_i)
        line_i.tx_clk_glitch
        |=> evt_q[bsem_pkg::EV_GLT]) else $error("tx glitch event lost");
    a_cs_change_sets: assert property (@(posedge mclk_i) disable iff (srst_i)
        (carrier_sense_i ^ cs_q)
        |=> evt_q[bsem_pkg::EV_DCC]) else $error("carrier change event lost");
    a_send_fault_sets: assert property (@(posedge mclk_i) disable iff (srst_i)
        (line_i.tx_msg_active & (line_i.tx_cts_lost | line_i.tx_underrun))
        |=> evt_q[bsem_pkg::EV_TXE]) else $error("send fault event lost");
    a_char_rx_sets: assert property (@(posedge mclk_i) disable iff (srst_i)
        stored
        |=> evt_q[bsem_pkg::EV_RCH] && rx_store_o.valid) else $error("char received not flagged");
    a_buf_sent_sets: assert property (@(posedge mclk_i) disable iff (srst_i)
        line_i.tx_last_bit
        |=> evt_q[bsem_pkg::EV_TX]) else $error("buffer sent event lost");
    a_gra_after_msg: assert property (@(posedge mclk_i) disable iff (srst_i)
        (gra_pend_q & ~line_i.tx_msg_active)
        |=> evt_q[bsem_pkg::EV_GRA]) else $error("graceful done late");
    a_evt_holds_idle: assert property (@(posedge mclk_i) disable iff (srst_i)
        (ev_clr == 16'h0000) && (ev_set == 16'h0000)
        |=> $stable(evt_q)) else $error("event register changed alone");
    a_irq_stays_high: assert property (@(posedge mclk_i) disable iff (srst_i)
        ((evt_q & msk_q) != 16'h0000) && !(wr_acc & hit_evt)
        |=> irq_o) else $error("irq dropped with events pending");
    a_mask_write_full: assert property (@(posedge mclk_i) disable iff (srst_i)
        (wr_acc & hit_msk & (pstrb_i == 4'hf))
        |=> msk_q == ($past(pwdata_i[15:0]) & bsem_pkg::EV_VALID)) else $error("mask write lost");
    a_status_read: assert property (@(posedge mclk_i) disable iff (srst_i)
        (psel_i & ~penable_i & ~pwrite_i & hit_sts)
        |=> prdata_o == {30'h00000000, $past(cs_q), 1'b0}) else $error("status read wrong");
    a_txlen_untouched: assert property (@(posedge mclk_i) disable iff (srst_i)
        !(wr_acc & hit_txl)
        |=> $stable(tx_length_o)) else $error("tx length altered");
    a_sync_not_summed: assert property (@(posedge mclk_i) disable iff (srst_i)
        (rc & is_syn & ~cmd_crst)
        |=> $stable(check_sum_o) && !rx_store_o.valid) else $error("sync char summed");
    a_restart_clears: assert property (@(posedge mclk_i) disable iff (srst_i)
        cmd_crst
        |=> check_sum_o == 8'h00) else $error("check restart ignored");
    a_ctl_needs_esc: assert property (@(posedge mclk_i) disable iff (srst_i)
        (rc & trn_q & is_ctl & ~esc_seen_q)
        |=> !block_end_o) else $error("control seen without escape");
    a_hunt_ignores: assert property (@(posedge mclk_i) disable iff (srst_i)
        (rx_char_i.valid & hunt_q)
        |=> !rx_store_o.valid && !block_end_o) else $error("char taken while hunting");
    a_hunt_cmd_starts: assert property (@(posedge mclk_i) disable iff (srst_i)
        cmd_hunt
        |=> !rx_hunting_o) else $error("hunt command ignored");
    a_etx_expects_chk: assert property (@(posedge mclk_i) disable iff (srst_i)
        (rc & ctl_ok & ~is_enq)
        |=> block_end_o && check_expected_o) else $error("check not expected");

    c_irq_raised: cover property (@(posedge mclk_i) disable iff (srst_i) $rose(irq_o));
    c_busy_event: cover property (@(posedge mclk_i) disable iff (srst_i) dropped);
    c_gra_pending: cover property (@(posedge mclk_i) disable iff (srst_i) gra_pend_q ##1 !gra_pend_q);
    c_block_end: cover property (@(posedge mclk_i) disable iff (srst_i) block_end_o && check_expected_o);
    c_escaped_ctl: cover property (@(posedge mclk_i) disable iff (srst_i) rc & trn_q & esc_seen_q & is_ctl);
endmodule

// >>> bsem_pkg.sv
// Package with register map, field positions and carriers for the event block
package bsem_pkg;
    localparam logic [11:0] EVT_OFF  = 12'h000;
    localparam logic [11:0] MSK_OFF  = 12'h004;
    localparam logic [11:0] STS_OFF  = 12'h008;
    localparam logic [11:0] CTL_OFF  = 12'h00c;
    localparam logic [11:0] CHK_OFF  = 12'h010;
    localparam logic [11:0] DAT_OFF  = 12'h014;
    localparam logic [11:0] TXL_OFF  = 12'h018;
    localparam int EV_RX   = 0;
    localparam int EV_TX   = 1;
    localparam int EV_BSY  = 2;
    localparam int EV_RCH  = 3;
    localparam int EV_TXE  = 4;
    localparam int EV_GRA  = 7;
    localparam int EV_DCC  = 10;
    localparam int EV_GLT  = 11;
    localparam int EV_GLR  = 12;
    localparam logic [15:0] EV_VALID = 16'h1c9f;
    localparam logic [15:0] EV_RESET = 16'h0000;
    localparam logic [15:0] MSK_RESET = 16'h0000;
    localparam int STS_CS  = 1;
    localparam int CTL_TRN = 0;
    localparam int CTL_HUNT = 1;
    localparam int CTL_GRA = 2;
    localparam int CTL_CRST = 3;
    localparam logic [7:0] ESC_RESET = 8'h10;
    localparam logic [7:0] SYN_RESET = 8'h32;
    localparam logic [7:0] ENQ_RESET = 8'h2d;
    localparam logic [7:0] ETX_RESET = 8'h03;

    typedef struct packed {
        logic rx_clk_glitch;
        logic tx_clk_glitch;
        logic tx_msg_active;
        logic tx_cts_lost;
        logic tx_underrun;
        logic tx_last_bit;
        logic rx_buf_closed;
        logic rx_buf_avail;
    } bsem_line_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } bsem_char_s;
endpackage

// >>> tb_bisync_event_mask_status.sv
// Self-checking testbench for the bisync event, mask and status block
`timescale 1ns/1ps
module tb_bisync_event_mask_status;
    logic                 mclk_i = 1'b0;
    logic                 srst_i = 1'b1;
    logic                 psel_i = 1'b0;
    logic                 penable_i = 1'b0;
    logic                 pwrite_i = 1'b0;
    logic [11:0]          paddr_i = 12'h000;
    logic [31:0]          pwdata_i = 32'h0;
    logic [3:0]           pstrb_i = 4'hf;
    bsem_pkg::bsem_line_s line_i = '0;
    logic                 carrier_sense_i = 1'b0;
    bsem_pkg::bsem_char_s rx_char_i = '0;
    logic [31:0]          prdata_o;
    logic                 pready_o;
    logic                 pslverr_o;
    bsem_pkg::bsem_char_s rx_store_o;
    logic                 block_end_o;
    logic                 check_expected_o;
    logic [7:0]           check_sum_o;
    logic                 rx_hunting_o;
    logic [15:0]          tx_length_o;
    logic                 irq_o;
    int                   mismatches = 0;
    int                   checked = 0;
    logic [31:0]          r;
    logic                 e;
    logic [8:0]           st;
    logic                 be;
    logic                 ce;
    logic [7:0]           pl [6] = '{8'h80, 8'h40, 8'h28, 8'h30, 8'h04, 8'h02};
    logic [15:0]          ev [6] = '{16'h1000, 16'h0800, 16'h0010, 16'h0010, 16'h0002, 16'h0001};

    always #2.5 mclk_i = ~mclk_i;

    bsem_top DUT (.mclk_i(mclk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .line_i(line_i), .carrier_sense_i(carrier_sense_i), .rx_char_i(rx_char_i),
        .rx_store_o(rx_store_o), .block_end_o(block_end_o), .check_expected_o(check_expected_o),
        .check_sum_o(check_sum_o), .rx_hunting_o(rx_hunting_o), .tx_length_o(tx_length_o), .irq_o(irq_o));

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk_i);
            if (pready_o === 1'b1) break;
        end
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n == 50) begin
            mismatches++;
            end_of_test();
        end
    endtask

    task automatic pulse(input logic [7:0] v);
        @(posedge mclk_i);
        line_i <= v;
        @(posedge mclk_i);
        line_i <= 8'h00;
    endtask

    task automatic send(input logic [7:0] d);
        @(posedge mclk_i);
        rx_char_i <= {1'b1, d};
        @(posedge mclk_i);
        rx_char_i <= 9'h000;
        {st, be, ce} = '0;
        repeat (2) begin
            #1;
            st = st | rx_store_o;
            be = be | block_end_o;
            ce = ce | check_expected_o;
            @(posedge mclk_i);
        end
    endtask

    task automatic t_reset_regs();
        apb(0, bsem_pkg::EVT_OFF, 0); chk(r, 32'h0);
        apb(0, bsem_pkg::MSK_OFF, 0); chk(r, 32'h0);
        apb(1, bsem_pkg::MSK_OFF, 32'hffff);
        apb(0, bsem_pkg::MSK_OFF, 0); chk(r, {16'h0, bsem_pkg::EV_VALID});
        apb(1, bsem_pkg::MSK_OFF, 0);
        apb(0, 12'h0fc, 0); chk({e, r[30:0]}, 32'h80000000);
        $display("reset and mask test done");
    endtask

    task automatic t_events();
        for (int i = 0; i < 6; i++) begin
            apb(1, bsem_pkg::EVT_OFF, 32'hffff);
            pulse(pl[i]);
            apb(0, bsem_pkg::EVT_OFF, 0); chk(r, {16'h0, ev[i]});
        end
        $display("event test done");
    endtask

    task automatic t_clear_irq();
        apb(1, bsem_pkg::EVT_OFF, 32'hffff);
        pulse(8'h86);
        apb(1, bsem_pkg::MSK_OFF, 32'h0001);
        #1; chk(irq_o, 1);
        apb(1, bsem_pkg::EVT_OFF, 32'h1002);
        apb(0, bsem_pkg::EVT_OFF, 0); chk(r, 32'h0001);
        #1; chk(irq_o, 1);
        apb(1, bsem_pkg::EVT_OFF, 32'h0001);
        #1; chk(irq_o, 0);
        apb(1, bsem_pkg::MSK_OFF, 0);
        $display("clear and interrupt test done");
    endtask

    task automatic t_carrier_graceful();
        apb(1, bsem_pkg::EVT_OFF, 32'hffff);
        @(posedge mclk_i);
        carrier_sense_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        apb(0, bsem_pkg::STS_OFF, 0); chk(r[1], 1);
        apb(0, bsem_pkg::EVT_OFF, 0); chk(r, 32'h0400);
        apb(1, bsem_pkg::EVT_OFF, 32'hffff);
        line_i <= 8'h20;
        apb(1, bsem_pkg::CTL_OFF, 32'h4);
        apb(0, bsem_pkg::EVT_OFF, 0); chk(r, 32'h0);
        line_i <= 8'h00;
        repeat (3) @(posedge mclk_i);
        apb(0, bsem_pkg::EVT_OFF, 0); chk(r, 32'h0080);
        apb(1, bsem_pkg::EVT_OFF, 32'hffff);
        apb(1, bsem_pkg::CTL_OFF, 32'h4);
        apb(0, bsem_pkg::EVT_OFF, 0); chk(r, 32'h0080);
        $display("carrier and graceful test done");
    endtask

    task automatic t_receive();
        apb(1, bsem_pkg::EVT_OFF, 32'hffff);
        line_i <= 8'h01;
        apb(1, bsem_pkg::CTL_OFF, 32'h2);
        apb(1, bsem_pkg::CTL_OFF, 32'h8);
        send(8'h41); chk(st, 9'h141);
        chk(check_sum_o, 8'h41);
        apb(0, bsem_pkg::EVT_OFF, 0); chk(r, 32'h0008);
        send(8'h32); chk({st[8], check_sum_o}, 9'h041);
        apb(1, bsem_pkg::CTL_OFF, 32'h8);
        #1; chk(check_sum_o, 8'h00);
        send(8'h2d); chk({be, ce, rx_hunting_o}, 3'b101);
        apb(1, bsem_pkg::CTL_OFF, 32'h2);
        line_i <= 8'h00;
        apb(1, bsem_pkg::EVT_OFF, 32'hffff);
        send(8'h55); chk({st[8], rx_hunting_o}, 2'b01);
        apb(0, bsem_pkg::EVT_OFF, 0); chk(r, 32'h0004);
        $display("receive test done");
    endtask

    task automatic t_transparent();
        line_i <= 8'h01;
        apb(1, bsem_pkg::CTL_OFF, 32'h3);
        apb(1, bsem_pkg::CTL_OFF, 32'h9);
        send(8'h03); chk({st, be}, 10'h206);
        send(8'h10); chk({st[8], check_sum_o}, 9'h003);
        send(8'h03); chk({be, ce}, 2'b11);
        apb(1, bsem_pkg::TXL_OFF, 32'h5);
        apb(0, bsem_pkg::TXL_OFF, 0); chk({r[15:0], tx_length_o}, 32'h00050005);
        $display("transparent and length test done");
    endtask

    initial begin
        repeat (4) @(posedge mclk_i);
        srst_i <= 1'b0;
        t_reset_regs();
        t_events();
        t_clear_irq();
        t_carrier_graceful();
        t_receive();
        t_transparent();
        end_of_test();
    end
endmodule
